// >>> rtl/pma_pkg.sv
package pma_pkg;

  localparam int unsigned ADDR_W        = 24;
  localparam int unsigned WORD_W        = 16;
  localparam int unsigned INSTR_W       = 24;
  localparam int unsigned UPPER_IMPL_W  = 8;

  localparam logic [23:0] RESET_PC      = 24'h000000;
  localparam logic [23:0] JUMP_TGT_ADDR = 24'h000002;
  localparam logic [23:0] VECTOR_LIMIT  = 24'h000200;
  localparam logic [23:0] PC_STEP       = 24'h000002;

  localparam logic [7:0]  UPPER_PAD     = 8'h00;

  // Absolute jump opcode in instruction bits 23:16
  localparam logic [7:0]  JUMP_OPCODE   = 8'h04;

  typedef enum logic [3:0] {
    PMA_ST_RESET   = 4'b0001,
    PMA_ST_VECTOR  = 4'b0010,
    PMA_ST_TARGET  = 4'b0100,
    PMA_ST_RUN     = 4'b1000
  } pma_state_e;

endpackage : pma_pkg

// >>> rtl/pma_core.sv
// What this block does
// - Location holds 24-bit word, upper byte unimplemented
// - Lower word even address, upper word odd
// - Program counter steps by two, lower-word aligned
// - Low address range reserved for fixed vectors
// - After reset fetch starts at reset value
// - Reset jump and target word executed first
`timescale 1ns/100ps
`default_nettype none

module pma_core #(
  parameter logic [23:0] P_RESET_PC = pma_pkg::RESET_PC
) (
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  // Core fetch side
  input  wire logic        i_step,
  input  wire logic        i_back,
  input  wire logic        i_load,
  input  wire logic [23:0] i_load_addr,
  input  wire logic        i_vec_fetch,
  output logic [23:0]      o_program_counter,
  output logic [23:0]      o_instr,
  output logic             o_instr_valid,
  output logic             o_vec_area,
  output logic             o_load_denied,
  output logic             o_booting,
  // Flash array side, one 16-bit word per access
  output logic [23:0]      o_flash_addr,
  output logic             o_flash_rd,
  input  wire logic [15:0] i_flash_rdata,
  input  wire logic        i_flash_ack,
  // Word write path toward flash
  input  wire logic        i_wr,
  input  wire logic [23:0] i_wr_addr,
  input  wire logic [15:0] i_wr_data,
  output logic             o_flash_wr,
  output logic [23:0]      o_flash_waddr,
  output logic [15:0]      o_flash_wdata
);

  // Vector area test, shared by the load guard and the status output
  function automatic logic in_vectors(input logic [23:0] a);
    in_vectors = (a < pma_pkg::VECTOR_LIMIT);
  endfunction

  // Byte address of a word: lower word even, upper word odd
  function automatic logic [23:0] word_addr(input logic [23:0] loc, input logic upper);
    word_addr = {loc[23:1], upper};
  endfunction

  // Lower word plus the implemented byte of the upper word
  function automatic logic [23:0] asm_word(input logic [15:0] upper,
                                           input logic [15:0] lower);
    asm_word = {upper[pma_pkg::UPPER_IMPL_W-1:0], lower};
  endfunction

  // Word alignment: bit 0 never reaches the program counter
  function automatic logic [23:0] even_of(input logic [23:0] a);
    even_of = {a[23:1], 1'b0};
  endfunction

  pma_pkg::pma_state_e state, next_state;
  logic [23:0] pc, next_pc;
  logic        half, next_half;
  // Lower word held from the first ack of a location
  logic [15:0] low_word, next_low_word;
  logic [23:0] instr, next_instr;
  logic        instr_valid, next_instr_valid;
  logic        load_denied, next_load_denied;
  // Write path is a one-cycle register stage that pads odd-address data
  logic        wr_q, next_wr_q;
  logic [23:0] waddr_q, next_waddr_q;
  logic [15:0] wdata_q, next_wdata_q;

  // Limitations: nothing is buffered, so the core holds i_step or i_back
  // until o_instr_valid. The opcode byte of the reset word is not checked:
  // a wrong image still jumps, which keeps boot free of a trap path.
  // Acks are trusted to answer the address shown in the cycle they arrive.

  // Boot walks RESET, VECTOR, TARGET, RUN. Each location costs two acks,
  // lower word first; half selects which word the address points at.
  always_comb begin
    next_state       = state;
    next_pc          = pc;
    next_half        = half;
    next_low_word    = low_word;
    next_instr       = instr;
    next_instr_valid = 1'b0;
    next_load_denied = 1'b0;
    case (state)
      pma_pkg::PMA_ST_RESET: begin
        // One quiet cycle, so no read is raised straight out of reset
        next_pc   = even_of(P_RESET_PC);
        next_half = 1'b0;
        next_state = pma_pkg::PMA_ST_VECTOR;
      end
      pma_pkg::PMA_ST_VECTOR: begin
        // Jump word at reset location is taken whatever its opcode byte
        if (i_flash_ack) begin
          if (!half) begin
            next_low_word = i_flash_rdata;
            next_half     = 1'b1;
          end else begin
            next_instr       = asm_word(i_flash_rdata, low_word);
            next_instr_valid = 1'b1;
            next_half        = 1'b0;
            next_pc          = pma_pkg::JUMP_TGT_ADDR;
            next_state       = pma_pkg::PMA_ST_TARGET;
          end
        end
      end
      pma_pkg::PMA_ST_TARGET: begin
        // Next location carries the start-of-code address: low 16 bits in its lower word, top byte in its upper word
        if (i_flash_ack) begin
          if (!half) begin
            next_low_word = i_flash_rdata;
            next_half     = 1'b1;
          end else begin
            next_instr       = asm_word(i_flash_rdata, low_word);
            next_instr_valid = 1'b1;
            next_half        = 1'b0;
            // Full 24-bit target: lower word plus the upper byte
            next_pc          = even_of({i_flash_rdata[7:0], low_word});
            next_state       = pma_pkg::PMA_ST_RUN;
          end
        end
      end
      pma_pkg::PMA_ST_RUN: begin
        if (i_load) begin
          // Code may not be placed in the vector area, only vector fetches reach it.
          // An ack in the load cycle is dropped: its word belongs to the old pc,
          // and a refused load also drops it, so the fetch simply repeats.
          if (in_vectors(i_load_addr) && !i_vec_fetch) begin
            next_load_denied = 1'b1;
          end else begin
            next_pc   = even_of(i_load_addr);
            next_half = 1'b0;
          end
        end else if (i_flash_ack) begin
          if (!half) begin
            next_low_word = i_flash_rdata;
            next_half     = 1'b1;
          end else begin
            next_instr       = asm_word(i_flash_rdata, low_word);
            next_instr_valid = 1'b1;
            next_half        = 1'b0;
            // Retreat wins over step when both are asked for
            if (i_back) begin
              next_pc = pc - pma_pkg::PC_STEP;
            end else if (i_step) begin
              next_pc = pc + pma_pkg::PC_STEP;
            end
          end
        end
      end
      default: begin
        next_state = pma_pkg::PMA_ST_RESET;
      end
    endcase
  end

  always_comb begin
    next_wr_q    = i_wr;
    next_waddr_q = i_wr_addr;
    next_wdata_q = i_wr_data;
    // Flash sees the write one cycle late, which keeps its inputs registered.
    // Even address is a lower word and passes whole.
    // Odd address is the upper word: the top byte is dropped
    if (i_wr && i_wr_addr[0]) begin
      next_wdata_q = {pma_pkg::UPPER_PAD, i_wr_data[7:0]};
    end
  end

  // Reset loads constants only; the one-cycle pulses restart low
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state       <= pma_pkg::PMA_ST_RESET;
      pc          <= 24'h000000;
      half        <= 1'b0;
      low_word    <= 16'h0000;
      instr       <= 24'h000000;
      instr_valid <= 1'b0;
      load_denied <= 1'b0;
      wr_q        <= 1'b0;
      waddr_q     <= 24'h000000;
      wdata_q     <= 16'h0000;
    end else begin
      state       <= next_state;
      pc          <= next_pc;
      half        <= next_half;
      low_word    <= next_low_word;
      instr       <= next_instr;
      instr_valid <= next_instr_valid;
      load_denied <= next_load_denied;
      wr_q        <= next_wr_q;
      waddr_q     <= next_waddr_q;
      wdata_q     <= next_wdata_q;
    end
  end

  assign o_program_counter = pc;
  assign o_instr           = instr;
  assign o_instr_valid     = instr_valid;
  // o_vec_area and o_booting are decoded straight from pc and state; o_load_denied is registered
  assign o_vec_area        = in_vectors(pc);
  assign o_load_denied     = load_denied;
  assign o_booting         = (state != pma_pkg::PMA_ST_RUN);
  // Even address reads the lower word, odd the upper word
  assign o_flash_addr      = word_addr(pc, half);
  // No request while reset settles or while a load rewrites the pc;
  // an answer then would belong to an address that is about to vanish
  assign o_flash_rd        = (state != pma_pkg::PMA_ST_RESET) &&
                             !(state == pma_pkg::PMA_ST_RUN && i_load);
  assign o_flash_wr        = wr_q;
  assign o_flash_waddr     = waddr_q;
  assign o_flash_wdata     = wdata_q;

endmodule : pma_core

`default_nettype wire

// >>> test/pma_flash_model.sv
`timescale 1ns/100ps
`default_nettype none
module pma_flash_model (
  input  wire logic        i_clk, i_rd, i_slow,
  input  wire logic [23:0] i_addr,
  output logic      [15:0] o_rdata,
  output logic             o_ack
);
  logic [15:0] mem [0:1023];
  logic        gap = 1'b0;
  always @(posedge i_clk) begin
    o_ack   <= 1'b0;
    gap     <= ~gap;
    o_rdata <= ~o_rdata; // Idle bus never repeats a word
    if (i_rd && !o_ack && !(i_slow && gap)) begin
      o_ack   <= 1'b1;
      o_rdata <= mem[i_addr[9:0]];
    end
  end
endmodule // pma_flash_model
`default_nettype wire

// >>> test/pma_core_chk.sv
`timescale 1ns/100ps
`default_nettype none
module pma_core_chk (
  input wire logic        i_clk, i_srst, i_load, i_vec_fetch, o_load_denied, o_vec_area,
  input wire logic        o_booting, o_flash_rd,
  input wire logic [23:0] i_load_addr, o_program_counter, o_flash_addr
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  sequence s_held; o_booting && !o_flash_rd; endsequence
  sequence s_go; o_flash_rd && o_flash_addr == 24'h000000; endsequence
  property p_even; !o_program_counter[0]; endproperty
  property p_vec; o_vec_area == (o_program_counter < 24'h000200); endproperty
  property p_half; o_flash_addr[23:1] == o_program_counter[23:1]; endproperty
  property p_boot; o_booting |-> o_flash_addr < 24'h000004; endproperty
  property p_start; $fell(i_srst) |-> s_held ##1 s_go; endproperty
  property p_deny; i_load && !o_booting && !i_vec_fetch && i_load_addr < 24'h000200
    |=> o_load_denied && $stable(o_program_counter); endproperty
  property p_load; i_load && !o_booting && i_load_addr >= 24'h000200
    |=> o_program_counter == ($past(i_load_addr) & 24'hfffffe); endproperty
  property p_once; o_load_denied && !i_load |=> !o_load_denied; endproperty
  a_even: assert property (p_even) else $error("odd pc");
  a_vec: assert property (p_vec) else $error("vec flag");
  a_half: assert property (p_half) else $error("word half");
  a_boot: assert property (p_boot) else $error("boot read");
  a_start: assert property (p_start) else $error("reset fetch");
  a_deny: assert property (p_deny) else $error("deny");
  a_load: assert property (p_load) else $error("load");
  a_once: assert property (p_once) else $error("deny pulse");
endmodule // pma_core_chk
bind pma_core pma_core_chk u_chk (.i_clk, .i_srst, .i_load, .i_vec_fetch, .o_load_denied,
  .o_vec_area, .o_booting, .o_flash_rd, .i_load_addr, .o_program_counter, .o_flash_addr);
`default_nettype wire

// >>> test/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic        c = 1'b0, r = 1'b1, st = 1'b0, ld = 1'b0, vf = 1'b0, wr = 1'b0, sl = 1'b1;
  logic        bk = 1'b0;
  logic        rd, ak, iv, dn, bt, va, fwr;
  logic [23:0] la = 24'h000000, wa = 24'h000303, pc, ins, fa, fwa;
  logic [15:0] rq, fw;
  int          fail_count = 0, check_count = 0;
  initial forever #5 c = ~c;
  pma_core dut (.i_clk(c), .i_srst(r), .i_step(st), .i_back(bk), .i_load(ld),
    .i_load_addr(la), .i_vec_fetch(vf), .o_program_counter(pc), .o_instr(ins),
    .o_instr_valid(iv), .o_vec_area(va), .o_load_denied(dn), .o_booting(bt), .o_flash_addr(fa),
    .o_flash_rd(rd), .i_flash_rdata(rq), .i_flash_ack(ak), .i_wr(wr), .i_wr_addr(wa),
    .i_wr_data(16'hbeef), .o_flash_wr(fwr), .o_flash_waddr(fwa), .o_flash_wdata(fw));
  pma_flash_model fl (.i_clk(c), .i_rd(rd), .i_slow(sl), .i_addr(fa), .o_rdata(rq), .o_ack(ak));
  task automatic tk(int n = 1); repeat (n) @(posedge c); #1; endtask
  task automatic ck(string s, logic [23:0] g, logic [23:0] e);
    check_count++;
    if (g !== e) begin fail_count++; $display("BAD %s exp %h got %h", s, e, g); end
  endtask
  task automatic wv; for (int n = 0; n < 30 && iv !== 1'b1; n++) tk(); endtask
  task automatic wb; for (int n = 0; n < 60 && bt !== 1'b0; n++) tk(); endtask
  task automatic t_boot;
    wb();
    ck("start", pc, 24'h000300);
    ck("vec area low", {23'h000000, va}, 24'h000000);
    sl = 1'b0; tk(2); wv();
    ck("word", ins, 24'h345678);
    st = 1'b1; tk(); wv(); st = 1'b0; tk();
    ck("step", pc, 24'h000302);
  endtask
  task automatic t_load;
    ld = 1'b1; la = 24'h0001ff; tk();
    ck("deny", {pc[23:1], dn}, 24'h000303);
    vf = 1'b1; tk();
    ck("vector", pc, 24'h0001fe);
    ck("vec area", {23'h000000, va}, 24'h000001);
    la = 24'h000301; tk(); ld = 1'b0;
    ck("load", pc, 24'h000300);
  endtask
  task automatic t_back;
    bk = 1'b1; st = 1'b1; tk(); wv(); bk = 1'b0; st = 1'b0; tk();
    ck("back", pc, 24'h0002fe);
  endtask
  task automatic t_reset;
    r = 1'b1; tk(2);
    ck("rst pc", pc, 24'h000000);
    r = 1'b0; tk();
    ck("rst fetch", {bt, rd, fa[21:0]}, 24'hc00000);
    wb();
    ck("rst start", pc, 24'h000300);
  endtask
  task automatic t_write;
    wr = 1'b1; tk();
    ck("pad", {8'h00, fw}, 24'h0000ef);
    ck("wstrobe", {23'h000000, fwr}, 24'h000001);
    ck("waddr odd", fwa, 24'h000303);
    wa = 24'h000304; tk(); wr = 1'b0;
    ck("even word", {8'h00, fw}, 24'h00beef);
    ck("waddr even", fwa, 24'h000304);
    tk();
    ck("wstrobe off", {23'h000000, fwr}, 24'h000000);
  endtask
  task automatic test_done;
    if (fail_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    fl.mem[2] = 16'h0300; fl.mem[3] = 16'hff00; fl.mem[10'h300] = 16'h5678;
    fl.mem[10'h301] = 16'hab34; tk(3); r = 1'b0;
    t_boot(); t_load(); t_back(); t_write(); t_reset(); test_done();
  end
  initial begin #20000; fail_count++; test_done(); end
endmodule // testbench
`default_nettype wire
